// File: common/bcb_defs.svh
// constants for the cross-current and blanking timing configuration block
`ifndef BCB_DEFS_SVH
`define BCB_DEFS_SVH

// ----------------------------------------
// register addressing
// ----------------------------------------
`define BCB_ADDR_W          5
`define BCB_BANK_ACT        1'h0
`define BCB_OFS_MAP         5'h04
`define BCB_OFS_ACT         5'h05

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define BCB_MAP_RESET       16'h0000
`define BCB_ACT_RESET       16'h4924
`define BCB_ACT_RW_MASK     16'h7fff
`define BCB_SEL_W           2
`define BCB_CODE_W          3

// ----------------------------------------
// timing, clock period in ps (125 MHz)
// ----------------------------------------
`define BCB_CLK_PERIOD_PS   8000
`define BCB_CNT_W           12

`endif

// File: common/bcb_pkg.sv
// types shared by the timing configuration block
`default_nettype none
package bcb_pkg;

  typedef struct packed {
    logic       wrEn;
    logic       bank;
    logic [4:0] addr;
    logic [15:0] wdata;
  } bcb_req_s;

  typedef struct packed {
    logic       hsOn;
    logic       lsOn;
  } bcb_gate_s;

  typedef enum logic [1:0] {
    BCB_SET1,
    BCB_SET2,
    BCB_SET3,
    BCB_SET4
  } bcb_set_e;

endpackage
`default_nettype wire

// File: design/bcb_time_lut.sv
// decodes a three-bit timing code to a cycle count
`timescale 1ns/1ps
`default_nettype none
`include "bcb_defs.svh"

module bcb_time_lut (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  isMask,
  input  wire logic [2:0]            code,
  output logic [`BCB_CNT_W-1:0]      cycles
);

  // ----------------------------------------
  // typical times in ns, rounded down to cycles
  // ----------------------------------------
  localparam int DEAD_NS [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
  localparam int MASK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

  logic [`BCB_CNT_W-1:0] deadCyc;
  logic [`BCB_CNT_W-1:0] maskCyc;

  always_comb begin
    deadCyc = `BCB_CNT_W'((DEAD_NS[code] * 1000) / `BCB_CLK_PERIOD_PS);
    maskCyc = `BCB_CNT_W'((MASK_NS[code] * 1000) / `BCB_CLK_PERIOD_PS);
  end

  // registered output so the count is glitch free
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cycles <= '0;
    end else begin
      cycles <= isMask ? maskCyc : deadCyc;
    end
  end

endmodule
`default_nettype wire

// File: design/bcb_timing_cfg.sv
// timing set registers and per-bridge dead/mask time sequencing
// Summary of operation
// - two-bit selector per bridge picks timing set one to four
// - bridge n selector at bits 2n-1:2n-2 of map register
// - map register resets to zero, all bridges use set one
// - bank 0 offset 0x5 is active timing register; bank 1 differs
// - three-bit dead and mask fields packed from bit 0 upward
// - dead-time codes decode to 375 ns up to 16 us
// - mask-time codes decode to 625 ns up to 16 us
// - active timing fields reset to code 100, value 0x4924
// - bit 15 of active timing register reads zero
`timescale 1ns/1ps
`default_nettype none
`include "bcb_defs.svh"

module bcb_timing_cfg
  import bcb_pkg::*;
#(
  parameter int NUM_BRIDGES = 8
) (
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire bcb_pkg::bcb_req_s         regReq,
  output logic [15:0]                    regRdata,
  input  wire bcb_pkg::bcb_gate_s [NUM_BRIDGES-1:0] gateCmd,
  input  wire logic [NUM_BRIDGES-1:0]    overvoltRaw,
  input  wire logic [2:0]                set3Mask,
  input  wire logic [2:0]                set4Dead,
  input  wire logic [2:0]                set4Mask,
  output bcb_pkg::bcb_gate_s [NUM_BRIDGES-1:0] gateOut,
  output logic [NUM_BRIDGES-1:0]         overvoltFault
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [15:0] mapReg;
  logic [15:0] actReg;
  logic        hitMap;
  logic        hitAct;

  assign hitMap = regReq.bank == `BCB_BANK_ACT && regReq.addr == `BCB_OFS_MAP;
  assign hitAct = regReq.bank == `BCB_BANK_ACT && regReq.addr == `BCB_OFS_ACT;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mapReg <= `BCB_MAP_RESET;
    end else if (regReq.wrEn && hitMap) begin
      mapReg <= regReq.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      actReg <= `BCB_ACT_RESET;
    end else if (regReq.wrEn && hitAct) begin
      actReg <= regReq.wdata & `BCB_ACT_RW_MASK;
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (hitMap) begin
      regRdata <= mapReg;
    end else if (hitAct) begin
      regRdata <= actReg & `BCB_ACT_RW_MASK;
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------
  // per-bridge sequencing
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_BRIDGES; g++) begin : gBridge
      typedef enum logic [1:0] {IDLE, DEAD, ON} bcb_hb_state_e;
      bcb_hb_state_e          st;
      bcb_set_e               sel;
      logic [2:0]             deadCode;
      logic [2:0]             maskCode;
      logic [2:0]             lutCode;
      logic                   lutMask;
      logic [`BCB_CNT_W-1:0]  lutCyc;
      logic [`BCB_CNT_W-1:0]  cnt;
      logic [`BCB_CNT_W-1:0]  maskCnt;
      bcb_gate_s              target;
      bcb_gate_s              drive_reg;
      logic                   fault_reg;

      assign sel = bcb_set_e'(mapReg[2*g+1 -: 2]);

      always_comb begin
        case (sel)
          BCB_SET1: begin deadCode = actReg[2:0];   maskCode = actReg[5:3]; end
          BCB_SET2: begin deadCode = actReg[8:6];   maskCode = actReg[11:9]; end
          BCB_SET3: begin deadCode = actReg[14:12]; maskCode = set3Mask; end
          BCB_SET4: begin deadCode = set4Dead;      maskCode = set4Mask; end
          default:  begin deadCode = actReg[2:0];   maskCode = actReg[5:3]; end
        endcase
      end

      // set 3 dead time lives in the active register; only its mask time is external
      assign lutMask = (st == ON);
      assign lutCode = lutMask ? maskCode : deadCode;

      bcb_time_lut uLut (
        .core_clk (core_clk),
        .resetn   (resetn),
        .isMask   (lutMask),
        .code     (lutCode),
        .cycles   (lutCyc)
      );

      // a request with both switches on is treated as off, never shoot-through
      assign target = (gateCmd[g].hsOn && gateCmd[g].lsOn) ? '0 : gateCmd[g];

      // local register per bridge, so each output slice has one driver
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          st        <= IDLE;
          cnt       <= '0;
          drive_reg <= '0;
        end else begin
          case (st)
            IDLE: begin
              if (target != drive_reg) begin
                drive_reg <= '0;
                st        <= DEAD;
                cnt       <= '0;
              end
            end
            DEAD: begin
              // lut output is one cycle late, so compare after first cycle
              if (target == '0) begin
                st <= IDLE;
              end else if (cnt != '0 && cnt >= lutCyc) begin
                drive_reg <= target;
                st        <= ON;
              end else begin
                cnt <= cnt + 1'b1;
              end
            end
            ON: begin
              if (target != drive_reg) begin
                drive_reg <= '0;
                st        <= DEAD;
                cnt       <= '0;
              end
            end
            default: st <= IDLE;
          endcase
        end
      end

      assign gateOut[g] = drive_reg;

      // mask window after each turn-on
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          maskCnt <= '0;
        end else if (st != ON) begin
          maskCnt <= '0;
        end else if (maskCnt <= lutCyc) begin
          maskCnt <= maskCnt + 1'b1;
        end
      end

      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          fault_reg <= 1'b0;
        end else begin
          fault_reg <= overvoltRaw[g] && st == ON && maskCnt > lutCyc;
        end
      end

      assign overvoltFault[g] = fault_reg;

      // ----------------------------------------
      // checks
      // ----------------------------------------
      property p_noShoot;
        @(posedge core_clk) disable iff (!resetn)
          !(gateOut[g].hsOn && gateOut[g].lsOn);
      endproperty
      a_noShoot: assert property (p_noShoot) else $error("both switches on");

      property p_offBeforeOn;
        @(posedge core_clk) disable iff (!resetn)
          $rose(gateOut[g].hsOn) || $rose(gateOut[g].lsOn) |-> $past(gateOut[g]) == '0;
      endproperty
      a_offBeforeOn: assert property (p_offBeforeOn) else $error("no dead gap");

      property p_maskedEarly;
        @(posedge core_clk) disable iff (!resetn)
          $rose(st == ON) |-> !overvoltFault[g] [*2];
      endproperty
      a_maskedEarly: assert property (p_maskedEarly) else $error("fault inside mask");
    end
  endgenerate

  property p_bit15Zero;
    @(posedge core_clk) disable iff (!resetn)
      hitAct |=> regRdata[15] == 1'b0;
  endproperty
  a_bit15Zero: assert property (p_bit15Zero) else $error("reserved bit read one");

  property p_actWrite;
    @(posedge core_clk) disable iff (!resetn)
      regReq.wrEn && hitAct |=> actReg == ($past(regReq.wdata) & 16'h7fff);
  endproperty
  a_actWrite: assert property (p_actWrite) else $error("active write lost");

  property p_mapWrite;
    @(posedge core_clk) disable iff (!resetn)
      regReq.wrEn && hitMap |=> mapReg == $past(regReq.wdata);
  endproperty
  a_mapWrite: assert property (p_mapWrite) else $error("map write lost");

  property p_bankOther;
    @(posedge core_clk) disable iff (!resetn)
      regReq.wrEn && regReq.bank != 1'b0 |=> $stable(actReg) && $stable(mapReg);
  endproperty
  a_bankOther: assert property (p_bankOther) else $error("bank 1 write hit bank 0");

  property p_readBack;
    @(posedge core_clk) disable iff (!resetn)
      hitMap && !regReq.wrEn |=> regRdata == $past(mapReg);
  endproperty
  a_readBack: assert property (p_readBack) else $error("map readback wrong");

endmodule
`default_nettype wire

// File: sim/bcb_host_model.sv
// host side register access model for the timing block
`timescale 1ns/1ps
`default_nettype none
module bcb_host_model
  import bcb_pkg::*;
(
  input  wire logic             core_clk,
  output var  bcb_pkg::bcb_req_s regReq,
  input  wire logic [15:0]      regRdata
);
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // no drive-current port here, so 16 us codes go in unchecked
  initial regReq = '0;
  // write is taken at the next edge, then the strobe drops
  task automatic wr(input logic bank, input logic [4:0] addr, input logic [15:0] data);
    @(posedge core_clk);
    regReq <= '{1'b1, bank, addr, data};
    @(posedge core_clk);
    regReq.wrEn <= 1'b0;
  endtask
  // read data trails the address by one edge
  task automatic rd(input logic bank, input logic [4:0] addr, output logic [15:0] data);
    @(posedge core_clk);
    regReq <= '{1'b0, bank, addr, ~regReq.wdata};
    @(posedge core_clk);
    #1;
    data = regRdata;
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the timing configuration block
`timescale 1ns/1ps
`default_nettype none
`include "bcb_defs.svh"
module tb;
  import bcb_pkg::*;
  logic             core_clk;
  logic             resetn;
  bcb_req_s         regReq;
  logic [15:0]      regRdata, rd, w, mapExp, actExp;
  bcb_gate_s [7:0]  gateCmd, gateOut;
  logic [7:0]       overvoltRaw, overvoltFault;
  logic [2:0]       set3Mask, set4Dead, set4Mask;
  int               mismatches, checked, seed;
  int               deadCyc[8] = '{46, 78, 125, 187, 250, 375, 500, 2000};
  int               maskCyc[8] = '{78, 125, 156, 187, 250, 375, 500, 2000};
  bcb_host_model host (.core_clk(core_clk), .regReq(regReq), .regRdata(regRdata));
  // set 3 dead time lives in the register, only its mask code is an input
  bcb_timing_cfg #(.NUM_BRIDGES(8)) DUT (
    .core_clk(core_clk), .resetn(resetn), .regReq(regReq), .regRdata(regRdata),
    .gateCmd(gateCmd), .overvoltRaw(overvoltRaw), .set3Mask(set3Mask),
    .set4Dead(set4Dead), .set4Mask(set4Mask), .gateOut(gateOut), .overvoltFault(overvoltFault));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // cycle rounding and pipeline stages allow a few extra edges
  task automatic chkCyc(input string what, input int lo, input int got);
    checked++;
    if (got < lo || got > lo + 5) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, lo, got);
    end
  endtask
  task automatic rdChk(input string what, input logic bank, input logic [4:0] addr, input logic [15:0] exp);
    host.rd(bank, addr, rd);
    chk(what, exp, rd);
  endtask
  task automatic waitOn(input int b, input int kind, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (n < 2200 && (kind == 0 ? gateOut[b].hsOn !== 1'b1 :
               kind == 1 ? gateOut[b].lsOn !== 1'b1 : overvoltFault[b] !== 1'b1));
  endtask
  // high side on, then swap to low side with overvoltage already present
  task automatic measure(input int b, input int dExp, input int mExp);
    int n;
    @(posedge core_clk);
    gateCmd[b] <= 2'b10;
    waitOn(b, 0, n);
    @(posedge core_clk);
    gateCmd[b] <= 2'b01;
    overvoltRaw[b] <= 1'b1;
    waitOn(b, 1, n);
    chkCyc("dead time cycles", dExp, n);
    waitOn(b, 2, n);
    chkCyc("mask time cycles", mExp, n);
    @(posedge core_clk);
    gateCmd[b] <= 2'b00;
    overvoltRaw[b] <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic close_out;
    $display("counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    mismatches = 0;
    checked = 0;
    seed = 32'h5970ce28;
    resetn = 1'b0;
    gateCmd = '0;
    overvoltRaw = '0;
    set3Mask = 3'h2;
    set4Dead = 3'h3;
    set4Mask = 3'h3;
    mapExp = `BCB_MAP_RESET;
    actExp = `BCB_ACT_RESET;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rdChk("map reset", 1'b0, `BCB_OFS_MAP, 16'h0000);
    rdChk("act reset", 1'b0, `BCB_OFS_ACT, 16'h4924);
    measure(0, 250, 250);
    // both switches requested must leave the bridge off
    @(posedge core_clk);
    gateCmd[1] <= 2'b11;
    repeat (300) @(posedge core_clk);
    #1;
    chk("both on request", 16'h0000, {14'h0000, gateOut[1]});
    @(posedge core_clk);
    gateCmd[1] <= 2'b00;
    repeat (4) @(posedge core_clk);
    $display("test reset values done");
    repeat (4) begin
      w = 16'($random(seed));
      host.wr(1'b0, `BCB_OFS_ACT, w);
      actExp = w & 16'h7fff;
      w = 16'($random(seed));
      host.wr(1'b0, `BCB_OFS_MAP, w);
      mapExp = w;
      rdChk("act readback", 1'b0, `BCB_OFS_ACT, actExp);
      rdChk("map readback", 1'b0, `BCB_OFS_MAP, mapExp);
    end
    host.wr(1'b0, `BCB_OFS_ACT, 16'hffff);
    actExp = 16'h7fff;
    rdChk("act reserved bit", 1'b0, `BCB_OFS_ACT, actExp);
    host.wr(1'b1, `BCB_OFS_ACT, 16'h0000);
    rdChk("bank1 read", 1'b1, `BCB_OFS_ACT, 16'h0000);
    rdChk("act after bank1 write", 1'b0, `BCB_OFS_ACT, actExp);
    rdChk("unmapped read", 1'b0, 5'h1f, 16'h0000);
    $display("test register access done");
    host.wr(1'b0, `BCB_OFS_MAP, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      host.wr(1'b0, `BCB_OFS_ACT, {1'b0, 3'(c), 3'(c), 3'(c), 3'(c), 3'(c)});
      measure(c, deadCyc[c], maskCyc[c]);
    end
    $display("test code sweep done");
    host.wr(1'b0, `BCB_OFS_ACT, {1'b0, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0});
    for (int b = 0; b < 8; b++)
      w[2*b +: 2] = 2'((b + 1) % 4);
    host.wr(1'b0, `BCB_OFS_MAP, w);
    for (int b = 0; b < 8; b++)
      measure(b, deadCyc[(b + 1) % 4], maskCyc[(b + 1) % 4]);
    $display("test bridge mapping done");
    close_out();
  end
endmodule
`default_nettype wire
